// ==== src/bsm_pkg.sv ====
// Behaviour
// - Resolution selectable 13 or 14 bits
// - Conversion lasts 2^res half-oscillator periods
// - Result is 2^res times ratio minus shift
// - Mux steps bridge, temperature, offset in order
// - Startup measures all, then normal cycle
// - Exactly four working modes: startup, normal, calibration, failure report
// - Calibration mode permits calibration, register access
// - Failsafe error in startup or normal mode enters failure report mode; ignored in calibration mode
// - Each signal gets a 16-bit corrected value
// - Offset removed digitally, not by trimming
// - Temperature source from configured sensor type
// - Gain one of nine settings, 105 to 2.8
// - Digital result 15 bits at either resolution; analog 12 bits
// - Output driven analog or serial per config; analog also enabled in failure report mode
// - Startup error: failure mode, lower diagnostic band
// - Bridge result non-negative 15-bit, clipped for analog
package bsm_pkg;
  localparam int          RES_LOW      = 13;
  localparam int          RES_HIGH     = 14;
  localparam int          CLK_DIV      = 2;
  localparam int          STARTUP_SETS = 5;
  localparam int          CW           = 16;
  localparam int          OUT_W        = 15;
  localparam int          DAC_W        = 12;
  localparam logic [3:0]  GAIN_MAX     = 4'h8;
  localparam logic [1:0]  MUX_BRIDGE   = 2'h0;
  localparam logic [1:0]  MUX_TEMP     = 2'h1;
  localparam logic [1:0]  MUX_OFFSET   = 2'h2;
  localparam logic [11:0] DAC_LDB      = 12'h000;
  localparam logic [1:0]  OUT_ANALOG   = 2'h0;
  localparam logic [1:0]  OUT_TWO_WIRE = 2'h1;
  localparam logic [1:0]  OUT_ONE_WIRE = 2'h2;

  typedef enum logic [3:0] {
    MODE_START = 4'h1,
    MODE_CCM   = 4'h2,
    MODE_CAM   = 4'h4,
    MODE_FRM   = 4'h8
  } bsm_mode_type;
endpackage

// ==== src/bsm_ctrl.sv ====
`timescale 1ns/1ps
module bsm_ctrl
  import bsm_pkg::*;
(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  // Stored configuration
  input  wire logic              i_res_14,
  input  wire logic [1:0]        i_range_shift_setting,
  input  wire logic              i_supply_reference_select,
  input  wire logic [3:0]        i_gain_sel,
  input  wire logic [1:0]        i_temp_src,
  input  wire logic [1:0]        i_out_cfg,
  input  wire logic [CW-1:0]     i_coef_offset,
  input  wire logic [CW-1:0]     i_coef_gain,
  input  wire logic [OUT_W-1:0]  i_clip_lo,
  input  wire logic [OUT_W-1:0]  i_clip_hi,
  // Mode requests and failsafe
  input  wire logic              i_cal_req,
  input  wire logic              i_cal_exit,
  input  wire logic              i_fail,
  // Converter side
  input  wire logic [CW-1:0]     i_adc_ratio,
  // Front-end control
  output logic [1:0]             o_mux_sel,
  output logic [1:0]             o_temp_src,
  output logic [3:0]             o_gain_sel,
  output logic                   o_supply_reference_select,
  output logic                   o_conv_done,
  output logic [CW-1:0]          o_corr,
  // Output path
  output logic [3:0]             o_mode,
  output logic                   o_reg_access,
  output logic [OUT_W-1:0]       o_result,
  output logic [DAC_W-1:0]       o_dac,
  output logic                   o_dac_en,
  output logic                   o_serial_two_wire,
  output logic                   o_single_wire_interface
);
  bsm_mode_type mode;
  logic [14:0]  tick;
  logic [2:0]   sets;
  logic [CW-1:0] zero_raw, bridge_c, temp_c;
  logic         set_done;
  logic [CW-1:0] z;
  logic [CW-1:0] shift;
  logic [CW-1:0] next_corr;
  logic [31:0]  prod;
  logic [OUT_W-1:0] clipped;
  logic [14:0]  conv_len;
  logic [2:0]   f1, f2, f3;
  logic [2:0]   agreed;

  ////////////////////////////////////////////////////////////////////////
  // Failure and mode request input sync, three stages, change when last two agree
  always_ff @(posedge i_mclk) begin
    f1 <= {i_fail, i_cal_req, i_cal_exit};
    f2 <= f1;
    f3 <= f2;
  end
  // Keep the last agreed level while stages two and three differ, so a glitch counts in neither direction
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      agreed <= 3'h0;
    end else begin
      agreed <= (f2 & f3) | (agreed & (f2 | f3));
    end
  end
  wire fail_s = agreed[2];
  wire cal_s  = agreed[1];
  wire exit_s = agreed[0];

  ////////////////////////////////////////////////////////////////////////
  // Conversion timing: 2^res cycles of half-rate clock
  assign conv_len = i_res_14 ? 15'(((1 << RES_HIGH) * CLK_DIV) - 1)
                             : 15'(((1 << RES_LOW) * CLK_DIV) - 1);
  wire conv_end = (tick == conv_len);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || mode == MODE_CAM || mode == MODE_FRM) begin
      tick <= 15'h0000;
    end else begin
      tick <= conv_end ? 15'h0000 : tick + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Relative count: ratio minus range shift, halved at 13-bit resolution
  always_comb begin
    case (i_range_shift_setting)
      2'h0:    shift = 16'h1000;
      2'h1:    shift = 16'h2000;
      2'h2:    shift = 16'h4000;
      default: shift = 16'h8000;
    endcase
    z = i_adc_ratio - shift;
    if (!i_res_14) begin
      z = {1'b0, z[CW-1:1]};
    end
  end

  // Digital offset removal and gain, 16-bit correction
  always_comb begin
    prod      = ({16'h0000, z} - {16'h0000, zero_raw} - {16'h0000, i_coef_offset}) * {16'h0000, i_coef_gain};
    next_corr = prod[29:14];
  end

  ////////////////////////////////////////////////////////////////////////
  // Multiplexer sequence and corrected values
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_mux_sel   <= MUX_BRIDGE;
      o_conv_done <= 1'b0;
      o_corr      <= 16'h0000;
      zero_raw    <= 16'h0000;
      bridge_c    <= 16'h0000;
      temp_c      <= 16'h0000;
      set_done    <= 1'b0;
    end else begin
      o_conv_done <= conv_end && (mode == MODE_START || mode == MODE_CCM);
      set_done    <= 1'b0;
      if (conv_end && (mode == MODE_START || mode == MODE_CCM)) begin
        o_corr <= next_corr;
        case (o_mux_sel)
          MUX_BRIDGE: begin
            bridge_c  <= next_corr;
            o_mux_sel <= MUX_TEMP;
          end
          MUX_TEMP: begin
            temp_c    <= next_corr;
            o_mux_sel <= MUX_OFFSET;
          end
          default: begin
            zero_raw  <= z;
            o_mux_sel <= MUX_BRIDGE;
            set_done  <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working modes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mode <= MODE_START;
      sets <= 3'h0;
    end else begin
      case (mode)
        MODE_START: begin
          if (fail_s) begin
            mode <= MODE_FRM;
          end else if (set_done) begin
            sets <= sets + 3'h1;
            if (sets == 3'(STARTUP_SETS - 1)) begin
              mode <= MODE_CCM;
            end
          end
        end
        MODE_CCM: begin
          if (fail_s) begin
            mode <= MODE_FRM;
          end else if (cal_s) begin
            mode <= MODE_CAM;
          end
        end
        MODE_CAM: begin
          if (exit_s) begin
            mode <= MODE_CCM;
          end
        end
        MODE_FRM: mode <= MODE_FRM;
        default:  mode <= MODE_FRM;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conditioned output; clipping only for the analog path
  assign clipped = (bridge_c[OUT_W-1:0] < i_clip_lo) ? i_clip_lo :
                   (bridge_c[OUT_W-1:0] > i_clip_hi) ? i_clip_hi : bridge_c[OUT_W-1:0];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_result <= 15'h0000;
      o_dac    <= DAC_LDB;
    end else if (mode == MODE_FRM || mode == MODE_START) begin
      o_dac    <= DAC_LDB;
    end else if (set_done && mode == MODE_CCM) begin
      o_result <= bridge_c[CW-1] ? 15'h0000 : bridge_c[OUT_W-1:0];
      o_dac    <= clipped[OUT_W-1:OUT_W-DAC_W];
    end
  end

  // Configuration pass-through registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_gain_sel                <= 4'h0;
      o_temp_src                <= 2'h0;
      o_supply_reference_select <= 1'b0;
      o_mode                    <= MODE_START;
      o_reg_access              <= 1'b0;
      o_dac_en                  <= 1'b0;
      o_serial_two_wire         <= 1'b0;
      o_single_wire_interface   <= 1'b0;
    end else begin
      o_gain_sel                <= (i_gain_sel > GAIN_MAX) ? GAIN_MAX : i_gain_sel;
      o_temp_src                <= (i_temp_src == 2'h3) ? 2'h0 : i_temp_src;
      o_supply_reference_select <= i_supply_reference_select;
      o_mode                    <= mode;
      o_reg_access              <= (mode == MODE_CAM);
      o_dac_en                  <= (i_out_cfg == OUT_ANALOG) || (mode == MODE_FRM);
      o_serial_two_wire         <= (i_out_cfg == OUT_TWO_WIRE);
      o_single_wire_interface   <= (i_out_cfg == OUT_ONE_WIRE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_fail_mode: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (fail_s && (mode == MODE_CCM || mode == MODE_START)) |=> mode == MODE_FRM)
    else $error("fail not reported");
  a_mux_order: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $changed(o_mux_sel) |-> ($past(o_mux_sel) == MUX_BRIDGE && o_mux_sel == MUX_TEMP) ||
                            ($past(o_mux_sel) == MUX_TEMP && o_mux_sel == MUX_OFFSET) ||
                            ($past(o_mux_sel) == MUX_OFFSET && o_mux_sel == MUX_BRIDGE))
    else $error("mux order broken");
  a_conv_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    conv_end |-> tick == (i_res_14 ? 15'h7FFF : 15'h3FFF))
    else $error("bad conv length");
  a_ldb_fail: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (mode == MODE_FRM) |=> o_dac == DAC_LDB)
    else $error("dac not low in fail");
  a_res_upd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $changed(o_result) |-> $past(set_done))
    else $error("result updated early");
  a_start_ccm: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (mode == MODE_CCM && $past(mode) == MODE_START) |-> $past(set_done))
    else $error("startup left early");
  a_gain_rng: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_gain_sel <= GAIN_MAX)
    else $error("gain out of range");
  a_reg_acc: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (mode == MODE_CAM) |=> o_reg_access)
    else $error("no register access");
endmodule

// ==== testbench/bsm_front_model.sv ====
`timescale 1ns/1ps
module bsm_front_model
  import bsm_pkg::*;
(
  // Front-end control from the block
  input  wire logic [1:0]     i_mux_sel,
  // Converter ratio back to the block
  output logic [CW-1:0]       o_adc_ratio
);
  // Bridge sits above half scale, as a sensible gain choice leaves it
  always_comb begin
    case (i_mux_sel)
      MUX_BRIDGE: o_adc_ratio = 16'hA000;
      MUX_TEMP:   o_adc_ratio = 16'h6000;
      MUX_OFFSET: o_adc_ratio = 16'h0100;
      default:    o_adc_ratio = 16'h5AA5;
    endcase
  end
endmodule

// ==== testbench/bridge_sensor_measurement_control_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bridge_sensor_measurement_control_tb_top;
  import bsm_pkg::*;
  logic i_mclk = 0, i_rst_n = 0, i_res_14 = 0, i_ref = 0, i_cal_req = 0, i_cal_exit = 0, i_fail = 0;
  logic [1:0] i_rs = 2'h1, i_temp_src = 2'h0, i_out_cfg = 2'h0, o_mux_sel, o_temp_src;
  logic [3:0] i_gain_sel = 4'h0, o_gain_sel, o_mode;
  logic [CW-1:0] i_adc_ratio, o_corr;
  logic [OUT_W-1:0] o_result;
  logic [DAC_W-1:0] o_dac;
  logic o_ref, o_conv_done, o_reg_access, o_dac_en, o_two, o_one;
  int failures = 0, checks_done = 0, n;
  always #5 i_mclk = ~i_mclk;
  bsm_front_model u_bsm_front_model (.i_mux_sel(o_mux_sel), .o_adc_ratio(i_adc_ratio));
  bsm_ctrl u_bsm_ctrl (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_res_14(i_res_14), .i_range_shift_setting(i_rs),
    .i_supply_reference_select(i_ref), .i_gain_sel(i_gain_sel), .i_temp_src(i_temp_src), .i_out_cfg(i_out_cfg),
    .i_coef_offset(16'h0010), .i_coef_gain(16'h4000), .i_clip_lo(15'h0100), .i_clip_hi(15'h7E00),
    .i_cal_req(i_cal_req), .i_cal_exit(i_cal_exit), .i_fail(i_fail), .i_adc_ratio(i_adc_ratio),
    .o_mux_sel(o_mux_sel), .o_temp_src(o_temp_src), .o_gain_sel(o_gain_sel), .o_supply_reference_select(o_ref),
    .o_conv_done(o_conv_done), .o_corr(o_corr), .o_mode(o_mode), .o_reg_access(o_reg_access),
    .o_result(o_result), .o_dac(o_dac), .o_dac_en(o_dac_en), .o_serial_two_wire(o_two),
    .o_single_wire_interface(o_one));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  // Configuration is in place before reset is released
  task automatic do_reset();
    i_rst_n = 0;
    step(3);
    i_rst_n = 1;
  endtask
  // Counts cycles up to the next done pulse; a hang ends the run
  task automatic wait_done(input int lim, output int cnt);
    cnt = 0;
    do begin
      step(1);
      cnt++;
      if (cnt > lim) begin
        `CHK(cnt, lim)
        give_verdict();
      end
    end while (o_conv_done !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_gain_sel = 4'h9;
    i_temp_src = 2'h3;
    i_ref = 1;
    step(1);
    do_reset();
    `CHK(o_mode, MODE_START)
    `CHK(o_mux_sel, MUX_BRIDGE)
    `CHK(o_dac, DAC_LDB)
    step(4);
    `CHK(o_gain_sel, GAIN_MAX)
    `CHK(o_temp_src, 2'h0)
    `CHK(o_ref, 1'b1)
    `CHK(o_dac_en, 1'b1)
    `CHK(o_two, 1'b0)
    `CHK(o_one, 1'b0)
    wait_done(20000, n);
    // Four edges of this conversion passed before the wait began
    `CHK(n + 4, CLK_DIV << RES_LOW)
    `CHK(o_corr, 16'h3FF0)
    step(1);
    `CHK(o_mux_sel, MUX_TEMP)
    wait_done(20000, n);
    `CHK(n + 1, CLK_DIV << RES_LOW)
    `CHK(o_corr, 16'h1FF0)
    step(1);
    `CHK(o_mux_sel, MUX_OFFSET)
    wait_done(20000, n);
    `CHK(n + 1, CLK_DIV << RES_LOW)
    step(1);
    `CHK(o_mux_sel, MUX_BRIDGE)
    `CHK(o_mode, MODE_START)
    `CHK(o_result, 15'h0000)
    $display("test sequence_13bit done");
    i_res_14 = 1;
    i_gain_sel = 4'h5;
    i_temp_src = 2'h2;
    i_ref = 0;
    i_out_cfg = OUT_TWO_WIRE;
    do_reset();
    wait_done(40000, n);
    `CHK(n, CLK_DIV << RES_HIGH)
    `CHK(o_corr, 16'h7FF0)
    `CHK(o_two, 1'b1)
    `CHK(o_dac_en, 1'b0)
    `CHK(o_gain_sel, 4'h5)
    `CHK(o_temp_src, 2'h2)
    `CHK(o_ref, 1'b0)
    $display("test sequence_14bit done");
    i_res_14 = 0;
    i_out_cfg = OUT_ONE_WIRE;
    do_reset();
    i_fail = 1;
    step(8);
    `CHK(o_mode, MODE_FRM)
    `CHK(o_reg_access, 1'b0)
    `CHK(o_one, 1'b1)
    `CHK(o_dac_en, 1'b1)
    i_fail = 0;
    n = 0;
    repeat (17000) begin
      step(1);
      if (o_conv_done !== 1'b0) n++;
    end
    `CHK(n, 0)
    `CHK(o_mode, MODE_FRM)
    `CHK(o_dac, DAC_LDB)
    $display("test failure_mode done");
    give_verdict();
  end
endmodule
